// [shared/rsf_pkg.sv]
// Constants for the rheostat serial front end: word layout, commands,
// reset values and the few timing figures of the serial link.
// Assumes nothing beyond a SystemVerilog compiler; no imports are used.
package rsf_pkg;

	// Word layout, most significant bit first
	localparam int WORD_W = 16;
	localparam int CMD_MSB = 13;
	localparam int CMD_LSB = 10;
	localparam int DATA_W = 10;
	localparam int CMD_W = 4;
	localparam int PAD_W = 2;

	// Commands acted upon by this block
	localparam logic [3:0] CMD_NOP = 4'h0;
	localparam logic [3:0] CMD_WRITE = 4'h1;
	localparam logic [3:0] CMD_READ = 4'h2;

	// Reset values
	localparam logic [9:0] WIPER_RST = 10'h200;
	localparam logic [15:0] WORD_RST = 16'h0000;

	// Serial clock limit and core clock rate
	localparam int SCLK_MAX_MHZ = 50;
	localparam int MCLK_MHZ = 250;
	// Core cycles per fastest serial clock period, rounded down
	localparam int SCLK_MIN_CYC = MCLK_MHZ / SCLK_MAX_MHZ;

	// Core cycles waited after frame end so the word toggle has settled
	localparam int SETTLE_CYC = 3;
	localparam int SETTLE_W = 2;

endpackage : rsf_pkg

// [src/rsf_sync.sv]
// Three-stage synchroniser for a group of single-bit levels.
// Assumes each input bit is an independent level from another domain.
`timescale 1ns/10ps
module rsf_sync #(
	parameter int WIDTH = 2
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Levels in and filtered levels out
	input wire logic [WIDTH-1:0] async_i,
	input wire logic [WIDTH-1:0] rst_val_i,
	output logic [WIDTH-1:0] sync_o
);

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_bit
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic out_q;
			// Stages clear to zero; the output starts at its idle level
			always_ff @(posedge clk_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
				end
				else if (ce_i)
				begin
					s1_q <= async_i[g] ^ rst_val_i[g]; // Relative to idle level
					s2_q <= s1_q;
					s3_q <= s2_q;
				end
			end
			// Change accepted once second and third stages agree
			always_ff @(posedge clk_i or posedge rst_i)
			begin
				if (rst_i)
					out_q <= 1'b0;
				else if (ce_i && (s2_q == s3_q))
					out_q <= s3_q;
			end
			assign sync_o[g] = out_q ^ rst_val_i[g];
		end
	endgenerate

endmodule : rsf_sync

// [src/rsf_link.sv]
// Serial clock side of the front end: shift register, bit counter,
// completed-word hand-off and open-drain output drive.
// Assumes the serial clock idles low and runs only while a frame is open.
`timescale 1ns/10ps
module rsf_link #(
	parameter int WORD_W = rsf_pkg::WORD_W
) (
	// Link pins
	input wire logic sclk_i,
	input wire logic sync_n_i,
	input wire logic din_i,
	input wire logic rst_i,
	// Readback word from the core, static while a frame is open
	input wire logic rb_en_i,
	input wire logic [WORD_W-1:0] rb_word_i,
	// Completed word and its toggle towards the core
	output logic [WORD_W-1:0] word_o,
	output logic word_tgl_o,
	// Open-drain enable, high pulls the line low
	output logic sdo_oe_o
);

	logic [3:0] cnt_q;
	logic first_q;
	logic [WORD_W-1:0] sr_q;
	logic [WORD_W-1:0] sr_d;
	logic frame_rst;

	// Frame-select high or reset clears per-frame state
	assign frame_rst = sync_n_i | rst_i;

	// First word of a frame may carry the readback value
	always_comb
	begin
		if (first_q && rb_en_i)
			sr_d = {rb_word_i[WORD_W-2:0], din_i};
		else
			sr_d = {sr_q[WORD_W-2:0], din_i};
	end

	// Bit counter wraps every sixteen clocks
	always_ff @(negedge sclk_i or posedge frame_rst)
	begin
		if (frame_rst)
			cnt_q <= 4'h0;
		else
			cnt_q <= cnt_q + 4'h1;
	end

	// Marks the span before the first falling edge of a frame
	always_ff @(negedge sclk_i or posedge frame_rst)
	begin
		if (frame_rst)
			first_q <= 1'b1;
		else
			first_q <= 1'b0;
	end

	// Shift register, only moves while frame-select is low
	always_ff @(negedge sclk_i or posedge rst_i)
	begin
		if (rst_i)
			sr_q <= rsf_pkg::WORD_RST;
		else if (!sync_n_i)
			sr_q <= sr_d;
	end

	// Every sixteenth bit hands a whole word to the core
	always_ff @(negedge sclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			word_o <= rsf_pkg::WORD_RST;
			word_tgl_o <= 1'b0;
		end
		else if (!sync_n_i && (cnt_q == 4'hf))
		begin
			word_o <= sr_d;
			word_tgl_o <= ~word_tgl_o;
		end
	end

	// Output bit changes on the rising edge; zero pulls, one releases
	always_ff @(posedge sclk_i or posedge frame_rst)
	begin
		if (frame_rst)
			sdo_oe_o <= 1'b0;
		else if (first_q && rb_en_i)
			sdo_oe_o <= ~rb_word_i[WORD_W-1];
		else
			sdo_oe_o <= ~sr_q[WORD_W-1];
	end

endmodule : rsf_link

// [src/rsf_top.sv]
// Top of the rheostat serial front end: link logic on the serial clock,
// frame decode and wiper register on the core clock.
// Assumes a pull-up on the serial output line and a host that sends whole
// sixteen-bit words with frame-select high at least a few core cycles.
`timescale 1ns/10ps
module rsf_top (
	// Core clock, reset, enable
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Serial link from the host
	input wire logic sclk_i,
	input wire logic sync_n_i,
	input wire logic din_i,
	// Open-drain serial output
	output logic serial_out_line_o,
	output logic serial_out_line_oe_o,
	// Wiper and frame status
	output logic [rsf_pkg::DATA_W-1:0] wiper_register_o,
	output logic wiper_load_o,
	output logic frame_done_o,
	output logic frame_abort_o,
	output logic frame_active_o
);

	typedef enum logic [1:0] {
		RSF_IDLE,
		RSF_FRAME,
		RSF_SETTLE,
		RSF_DECIDE
	} rsf_state_e;

	rsf_state_e state_q;
	rsf_state_e state_d;

	logic [rsf_pkg::WORD_W-1:0] link_word;
	logic link_tgl;
	logic link_oe;
	logic [1:0] sync_lv;
	logic sync_n_s;
	logic tgl_s;
	logic tgl_prev_q;
	logic word_seen_q;
	logic [rsf_pkg::SETTLE_W-1:0] settle_q;
	logic rb_en_q;
	logic [rsf_pkg::WORD_W-1:0] rb_word_q;
	logic [rsf_pkg::CMD_W-1:0] cmd;
	logic [rsf_pkg::DATA_W-1:0] data;
	logic word_ok;

	// Serial clock domain; its speed limit is a timing matter only
	rsf_link #(
		.WORD_W(rsf_pkg::WORD_W)
	) u_link (
		.sclk_i(sclk_i),
		.sync_n_i(sync_n_i),
		.din_i(din_i),
		.rst_i(rst_i),
		.rb_en_i(rb_en_q),
		.rb_word_i(rb_word_q),
		.word_o(link_word),
		.word_tgl_o(link_tgl),
		.sdo_oe_o(link_oe)
	);

	// Frame-select and word toggle brought into the core domain
	rsf_sync #(
		.WIDTH(2)
	) u_sync (
		.clk_i(mclk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.async_i({link_tgl, sync_n_i}),
		.rst_val_i(2'b01),
		.sync_o(sync_lv)
	);
	assign sync_n_s = sync_lv[0] ^ 1'b1 ^ 1'b1;
	assign tgl_s = sync_lv[1];

	// Word fields; the two pad bits are ignored
	assign cmd = link_word[rsf_pkg::CMD_MSB:rsf_pkg::CMD_LSB];
	assign data = link_word[rsf_pkg::DATA_W-1:0];
	// Any toggle change in the frame means sixteen clocks were seen
	assign word_ok = word_seen_q || (tgl_s != tgl_prev_q);

	// Frame sequencing
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			RSF_IDLE:
				if (!sync_n_s)
					state_d = RSF_FRAME;
			RSF_FRAME:
				if (sync_n_s)
					state_d = RSF_SETTLE;
			RSF_SETTLE:
				if (settle_q == rsf_pkg::SETTLE_W'(rsf_pkg::SETTLE_CYC - 1))
					state_d = RSF_DECIDE;
			RSF_DECIDE:
				state_d = RSF_IDLE;
			default:
				state_d = RSF_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			state_q <= RSF_IDLE;
		else if (ce_i)
			state_q <= state_d;
	end

	// Wait lets the toggle catch up with frame-select
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			settle_q <= '0;
		else if (ce_i)
		begin
			if (state_q == RSF_SETTLE)
				settle_q <= settle_q + 1'b1;
			else
				settle_q <= '0;
		end
	end

	// Toggle flips since the frame opened; a 32-bit frame flips twice
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tgl_prev_q <= 1'b0;
			word_seen_q <= 1'b0;
		end
		else if (ce_i)
		begin
			tgl_prev_q <= tgl_s;
			if (state_q == RSF_IDLE)
				word_seen_q <= 1'b0;
			else if (tgl_s != tgl_prev_q)
				word_seen_q <= 1'b1;
		end
	end

	// Wiper register, written only by a complete write word
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			wiper_register_o <= rsf_pkg::WIPER_RST;
		else if (ce_i && (state_q == RSF_DECIDE) && word_ok &&
			(cmd == rsf_pkg::CMD_WRITE))
			wiper_register_o <= data;
	end

	// One-cycle status pulses at frame decision
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wiper_load_o <= 1'b0;
			frame_done_o <= 1'b0;
			frame_abort_o <= 1'b0;
		end
		else if (ce_i)
		begin
			wiper_load_o <= (state_q == RSF_DECIDE) && word_ok &&
				(cmd == rsf_pkg::CMD_WRITE);
			frame_done_o <= (state_q == RSF_DECIDE) && word_ok;
			frame_abort_o <= (state_q == RSF_DECIDE) && !word_ok;
		end
	end

	// Readback set up for the next frame; aborted frames leave it alone
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rb_en_q <= 1'b0;
			rb_word_q <= rsf_pkg::WORD_RST;
		end
		else if (ce_i && (state_q == RSF_DECIDE) && word_ok)
		begin
			rb_en_q <= (cmd == rsf_pkg::CMD_READ);
			rb_word_q <= {{(rsf_pkg::PAD_W + rsf_pkg::CMD_W){1'b0}},
				wiper_register_o};
		end
	end

	// Frame activity as seen by the core
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			frame_active_o <= 1'b0;
		else if (ce_i)
			frame_active_o <= !sync_n_s;
	end

	// Open drain: the data level is always low, only the enable moves
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			serial_out_line_o <= 1'b0;
		else if (ce_i)
			serial_out_line_o <= 1'b0;
	end
	assign serial_out_line_oe_o = link_oe;

endmodule : rsf_top

// [sim/rsf_top_assertions.sv]
// Port checks for the rheostat serial front end top.
// Assumes binding to rsf_top; core clock domain only.
`timescale 1ns/10ps
module rsf_top_assertions (
	// Core clock and controls
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic sync_n_i,
	// Outputs watched
	input wire logic serial_out_line_o,
	input wire logic serial_out_line_oe_o,
	input wire logic [rsf_pkg::DATA_W-1:0] wiper_register_o,
	input wire logic wiper_load_o,
	input wire logic frame_done_o,
	input wire logic frame_abort_o,
	input wire logic frame_active_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	// Frame outcome pulses
	property p_excl;
		!(frame_done_o && frame_abort_o);
	endproperty
	a_excl: assert property (p_excl) else $error("done with abort");
	property p_pulse;
		frame_done_o || frame_abort_o |=> !(frame_done_o || frame_abort_o);
	endproperty
	a_pulse: assert property (p_pulse) else $error("long pulse");
	property p_src;
		frame_done_o || frame_abort_o |-> sync_n_i && $past(sync_n_i, 3);
	endproperty
	a_src: assert property (p_src) else $error("early outcome");
	// Wiper only moves on a write load
	property p_load;
		wiper_load_o |-> frame_done_o;
	endproperty
	a_load: assert property (p_load) else $error("load alone");
	property p_hold;
		$changed(wiper_register_o) |-> wiper_load_o || $past(wiper_load_o);
	endproperty
	a_hold: assert property (p_hold) else $error("wiper moved");
	// Open-drain behaviour
	property p_idle;
		sync_n_i && $past(sync_n_i) |-> !serial_out_line_oe_o;
	endproperty
	a_idle: assert property (p_idle) else $error("line held");
	property p_zero;
		serial_out_line_o == 1'b0;
	endproperty
	a_zero: assert property (p_zero) else $error("drives high");
	// Frame start seen
	property p_act;
		@(posedge mclk_i) disable iff (rst_i || !ce_i)
		$fell(sync_n_i) |-> ##[1:8] frame_active_o;
	endproperty
	a_act: assert property (p_act) else $error("no frame");

	// Main scenarios reached
	c_load: cover property (wiper_load_o);
	c_abort: cover property (frame_abort_o);
	c_oe: cover property (serial_out_line_oe_o);
endmodule : rsf_top_assertions

// [sim/rsf_host.sv]
// Host controller model: frames of up to 32 bits, MSB first, 125 ns serial clock.
// Assumes the bench resolves the open-drain line with a pull-up.
`timescale 1ns/10ps
module rsf_host (
	// Link pins
	output logic sclk_o,
	output logic sync_n_o,
	output logic din_o,
	input wire logic sdo_i
);
	logic lclk = 1'b0;
	logic run = 1'b0;
	logic [15:0] rd_q = 16'h0000;
	initial sync_n_o = 1'b1;
	initial din_o = 1'b0;
	// Free link clock, gated so it stands still outside frames
	initial #17 forever #62.5 lclk = ~lclk;
	assign sclk_o = lclk & run;
	// Send n bits of w; line sampled at each falling edge
	task send(input logic [31:0] w, input int n);
		@(negedge lclk);
		sync_n_o <= 1'b0;
		@(negedge lclk);
		run <= 1'b1;
		for (int i = n - 1; i >= 0; i--)
		begin
			@(posedge lclk);
			din_o <= w[i];
			@(negedge lclk);
			rd_q <= {rd_q[14:0], sdo_i};
		end
		run <= 1'b0;
		@(negedge lclk);
		sync_n_o <= 1'b1;
		din_o <= ~din_o;
		repeat (4) @(negedge lclk);
	endtask : send
endmodule : rsf_host

// [sim/tb_rheostat_serial_frontend.sv]
// Bench for the front end: host model frames, random write data.
// Assumes rsf_top, rsf_host and the checker are compiled first.
`timescale 1ns/10ps
module tb_rheostat_serial_frontend;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	wire sclk, sync_n, din;
	logic sol, sol_oe, load, done, abort, act;
	logic [9:0] wiper;
	logic [9:0] d;
	logic [9:0] exp_w = rsf_pkg::WIPER_RST;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	int n_done = 0;
	int n_abort = 0;
	int n_load = 0;
	// Pull-up on the open-drain line
	wire line = sol_oe ? sol : 1'b1;

	always #2 mclk_i = ~mclk_i;

	rsf_host u_host (.sclk_o(sclk), .sync_n_o(sync_n), .din_o(din),
		.sdo_i(line));
	rsf_top u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
		.sclk_i(sclk), .sync_n_i(sync_n), .din_i(din),
		.serial_out_line_o(sol), .serial_out_line_oe_o(sol_oe),
		.wiper_register_o(wiper), .wiper_load_o(load),
		.frame_done_o(done), .frame_abort_o(abort),
		.frame_active_o(act));

	task end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	// Expected 16-bit word: zero pad, command, data
	function automatic logic [15:0] word_of(input logic [3:0] c,
		input logic [9:0] v);
		return {2'b00, c, v};
	endfunction : word_of

	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Pulse counters and hang limit
	always @(posedge mclk_i)
	begin
		if (done === 1'b1) n_done++;
		if (abort === 1'b1) n_abort++;
		if (load === 1'b1) n_load++;
		cyc++;
		if (cyc == 40000)
		begin
			err_total++;
			end_of_test();
		end
	end

	// One frame, then wiper and outcome counts
	task frame(input logic [31:0] w, input int n, nd, na, nl);
		int d0, a0, l0;
		d0 = n_done;
		a0 = n_abort;
		l0 = n_load;
		u_host.send(w, n);
		chk(16'(wiper), 16'(exp_w));
		chk(16'(n_done - d0), 16'(nd));
		chk(16'(n_abort - a0), 16'(na));
		chk(16'(n_load - l0), 16'(nl));
		chk(16'(act), 16'h0000);
	endtask : frame

	initial
	begin
		void'($urandom(32'h13e7_f38a));
		repeat (12) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		// Writes with extreme and random data
		for (int i = 0; i < 6; i++)
		begin
			d = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : 10'($urandom());
			exp_w = d;
			frame({18'h0, rsf_pkg::CMD_WRITE, d}, 16, 1, 0, 1);
		end
		$display("test write done");
		// Short frames are dropped
		for (int i = 0; i < 3; i++)
		begin
			d = 10'(1 + $urandom() % 14);
			if (i < 2) d = (i == 0) ? 10'd1 : 10'd15;
			frame({18'h0, rsf_pkg::CMD_WRITE, ~exp_w}, int'(d), 0, 1, 0);
		end
		$display("test abort done");
		// Core frozen by clock enable ignores a whole write frame
		@(posedge mclk_i);
		ce_i <= 1'b0;
		frame({18'h0, rsf_pkg::CMD_WRITE, ~exp_w}, 16, 0, 0, 0);
		@(posedge mclk_i);
		ce_i <= 1'b1;
		repeat (8) @(posedge mclk_i);
		chk(16'(wiper), 16'(exp_w));
		$display("test enable done");
		// Undefined commands 3 to 15 leave the wiper alone
		for (int c = 3; c < 16; c++)
			frame({18'h0, 4'(c), ~exp_w}, 16, 1, 0, 0);
		$display("test commands done");
		// Readback, then daisy chain of the previous word
		frame({18'h0, rsf_pkg::CMD_READ, 10'h000}, 16, 1, 0, 0);
		frame(32'h0000_0000, 16, 1, 0, 0);
		chk(u_host.rd_q, word_of(rsf_pkg::CMD_NOP, exp_w));
		frame(32'h0000_025a, 16, 1, 0, 0);
		frame(32'h0000_0000, 16, 1, 0, 0);
		chk(u_host.rd_q, 16'h025a);
		$display("test readback done");
		// Two words in one frame, last one decoded
		d = 10'($urandom());
		exp_w = d;
		frame({16'h0, 2'b00, rsf_pkg::CMD_WRITE, d}, 32, 1, 0, 1);
		$display("test long frame done");
		end_of_test();
	end
endmodule : tb_rheostat_serial_frontend

bind rsf_top rsf_top_assertions u_chk (.mclk_i(mclk_i), .rst_i(rst_i),
	.ce_i(ce_i), .sync_n_i(sync_n_i),
	.serial_out_line_o(serial_out_line_o),
	.serial_out_line_oe_o(serial_out_line_oe_o),
	.wiper_register_o(wiper_register_o), .wiper_load_o(wiper_load_o),
	.frame_done_o(frame_done_o), .frame_abort_o(frame_abort_o),
	.frame_active_o(frame_active_o));
